// File: rtl/ics_defines.svh
// constants of the interrupt channel system
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH
`define ICS_NUM_CHAN 256
`define ICS_NUM_CHAN_EXT 259
`define ICS_CHAN_W 9
`define ICS_CPU_CHAN 8
`define ICS_CPU_LAST 9'h007
`define ICS_IO_CHAN 248
`define ICS_DEPTH 8
`define ICS_DEPTH_W 4
`define ICS_RING0 2'h0
`define ICS_VEC_BASE 32'h0000_1000
`define ICS_VEC_SHIFT 4
`endif

// File: rtl/ics_pkg.sv
// types of the interrupt channel system
`include "ics_defines.svh"
package ics_pkg;
  // raise request from a processor's instruction
  typedef struct packed {
    logic valid;
    logic [`ICS_CHAN_W-1:0] src;
    logic [`ICS_CHAN_W-1:0] dst;
  } ics_raise_t;
  // delivery to ring 0 handler
  typedef struct packed {
    logic valid;
    logic [1:0] ring;
    logic [`ICS_CHAN_W-1:0] chan;
    logic [31:0] vector;
  } ics_take_t;
  typedef enum logic [1:0] {ICS_IDLE, ICS_TAKE, ICS_WAIT} ics_state_t;
endpackage : ics_pkg

// File: rtl/ics_prio.sv
// lowest-number-first picker over pending and enabled channels
`timescale 1ns/1ns
`include "ics_defines.svh"
module ics_prio #(
  parameter int N = `ICS_NUM_CHAN
) (
  // request vector
  input wire logic [N-1:0] req,
  // result
  output logic found,
  output logic [`ICS_CHAN_W-1:0] idx
);
  import ics_pkg::*;
  // scan from the top so the lowest channel wins
  always_comb begin
    found = 1'b0;
    idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        found = 1'b1;
        idx = i[`ICS_CHAN_W-1:0];
      end
    end
  end
endmodule : ics_prio

// File: rtl/ics_top.sv
// interrupt channel system: pending, enables, nesting and vectoring
//
// Overview of operation
// - every interrupt goes to ring 0 system software, never the running thread
// - a new interrupt during service nests on top of the current one, up to 8 deep; beyond that it waits pending
// - the handler entry is chosen from the target channel of the raise
// - 256 channels, or 259 in the extended variant
// - channels 0 to 7 are the CPU virtual channels
// - the 248 channels above them belong to I/O processors
// - any processor may raise an interrupt toward any channel
`timescale 1ns/1ns
`include "ics_defines.svh"
module ics_top #(
  parameter bit EXTENDED = 1'b0
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // raise requests from processors (same clock)
  input wire ics_pkg::ics_raise_t raise,
  // per-channel enable settings from the enable logic
  input wire logic [`ICS_NUM_CHAN_EXT-1:0] chan_en,
  // delivery to the processor
  output ics_pkg::ics_take_t take,
  input wire logic take_ack,
  input wire logic svc_done,
  // status
  output logic [`ICS_DEPTH_W-1:0] nest_depth,
  output logic raise_refused,
  output logic cpu_chan_taken
);
  import ics_pkg::*;

  // ---------------------------------------------
  // channel count
  // ---------------------------------------------
  // the extended variant adds three channels above the 256 of the base
  localparam int NCH = EXTENDED ? `ICS_NUM_CHAN_EXT : `ICS_NUM_CHAN;

  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  // handler entry address; a fixed stride keeps the entries apart per channel
  function automatic logic [31:0] vec_of(input logic [`ICS_CHAN_W-1:0] ch);
    vec_of = `ICS_VEC_BASE + ({23'h00_0000, ch} << `ICS_VEC_SHIFT);
  endfunction : vec_of

  // channel exists in this variant
  function automatic logic in_range(input logic [`ICS_CHAN_W-1:0] ch);
    in_range = ({23'h00_0000, ch} < NCH);
  endfunction : in_range

  // channel is one of the cpu virtual channels
  function automatic logic is_cpu(input logic [`ICS_CHAN_W-1:0] ch);
    is_cpu = (ch <= `ICS_CPU_LAST);
  endfunction : is_cpu

  // ---------------------------------------------
  // state
  // ---------------------------------------------
  // registers; pending bits cover the extended range, unused ones never set
  logic [`ICS_NUM_CHAN_EXT-1:0] pend_q;
  logic [`ICS_CHAN_W-1:0] stk_q [`ICS_DEPTH];
  logic [`ICS_DEPTH_W-1:0] depth_q;
  ics_state_t state_q;
  logic [`ICS_CHAN_W-1:0] sel_q;

  // combinational selection and handshake terms
  logic found;
  logic [`ICS_CHAN_W-1:0] pick;
  logic [`ICS_NUM_CHAN_EXT-1:0] elig;
  logic accept;
  logic raise_ok;
  logic room;
  logic take_fire;
  logic pop;

  // ---------------------------------------------
  // pending and selection
  // ---------------------------------------------
  // any in-range source may target any valid channel; out-of-range targets or sources are refused
  assign raise_ok = raise.valid && in_range(raise.dst) && in_range(raise.src);
  // disabled channels stay pending but are not offered
  assign elig = pend_q & chan_en;

  // lowest eligible channel is offered first
  ics_prio #(.N(`ICS_NUM_CHAN_EXT)) ics_prio_inst (
    .req(elig),
    .found(found),
    .idx(pick)
  );

  // the stack has room for one more nested interrupt
  assign room = (depth_q < `ICS_DEPTH);

  // nesting stops at full stack depth; deeper requests wait pending
  assign accept = (state_q == ICS_IDLE) && found && room;

  // set wins over the clear of the same channel
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= '0;
    end else begin
      if (accept) begin
        pend_q[pick] <= 1'b0;
      end
      if (raise_ok) begin
        pend_q[raise.dst] <= 1'b1;
      end
    end
  end

  // refused raise indication
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      raise_refused <= 1'b0;
    end else begin
      raise_refused <= raise.valid && !raise_ok;
    end
  end

  // ---------------------------------------------
  // handshake events
  // ---------------------------------------------
  // the offer is taken only at an edge where the processor acks in take state
  assign take_fire = (state_q == ICS_TAKE) && take_ack;
  // a finished handler unstacks; an ack in the same cycle wins and drops it
  assign pop = svc_done && !take_fire && (depth_q != '0);

  // ---------------------------------------------
  // delivery state machine
  // ---------------------------------------------
  // one offer at a time; the wait state lets the stack settle before a pick
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ICS_IDLE;
    end else begin
      case (state_q)
        ICS_IDLE: begin
          if (accept) begin
            state_q <= ICS_TAKE;
          end
        end
        ICS_TAKE: begin
          if (take_ack) begin
            state_q <= ICS_WAIT;
          end
        end
        ICS_WAIT: begin
          state_q <= ICS_IDLE;
        end
        default: begin
          state_q <= ICS_IDLE;
        end
      endcase
    end
  end

  // channel under offer, kept for the push onto the stack
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_q <= '0;
    end else if (accept) begin
      sel_q <= pick;
    end
  end

  // ---------------------------------------------
  // delivery record
  // ---------------------------------------------
  // record is loaded once per pick and held stable while offered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      take <= '0;
    end else if (accept) begin
      take.valid <= 1'b1;
      take.ring <= `ICS_RING0;
      take.chan <= pick;
      take.vector <= vec_of(pick);
    end else if (take_fire) begin
      take.valid <= 1'b0;
    end
  end

  // cpu flag follows every pick, so it names the latest channel offered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cpu_chan_taken <= 1'b0;
    end else if (accept) begin
      cpu_chan_taken <= is_cpu(pick);
    end
  end

  // ---------------------------------------------
  // interrupt nesting stack
  // ---------------------------------------------
  // stack pointer; accept stops at full depth so the push never overflows
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      depth_q <= '0;
    end else if (take_fire) begin
      depth_q <= depth_q + 4'h1;
    end else if (pop) begin
      depth_q <= depth_q - 4'h1;
    end
  end

  // channels in service, innermost on top; i/o channels nest like cpu ones
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < `ICS_DEPTH; i++) begin
        stk_q[i] <= '0;
      end
    end else if (take_fire) begin
      stk_q[depth_q[2:0]] <= sel_q;
    end
  end

  // ---------------------------------------------
  // status
  // ---------------------------------------------
  // depth is already a flop, so the status port needs no extra register
  assign nest_depth = depth_q;
endmodule : ics_top

// File: test/ics_chk.sv
// port assertions for the interrupt channel system
`timescale 1ns/1ns
module ics_chk #(
  parameter bit EXTENDED = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire ics_pkg::ics_raise_t raise,
  input wire logic [258:0] chan_en,
  input wire ics_pkg::ics_take_t take,
  input wire logic take_ack,
  input wire logic [3:0] nest_depth,
  input wire logic raise_refused,
  input wire logic cpu_chan_taken
);
  import ics_pkg::*;
  localparam int LIM = EXTENDED ? 259 : 256;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ring_zero:
    assert property (take.valid |-> take.ring == 2'h0) else $error("ring");
  a_vec_map:
    assert property (take.valid |-> take.vector == 32'h0000_1000 + {take.chan, 4'h0}) else $error("vec");
  a_cpu_flag:
    assert property (take.valid |-> cpu_chan_taken == (take.chan < 9'h008)) else $error("cpu");
  a_range_ref:
    assert property (raise.valid && (raise.dst >= LIM) |=> raise_refused) else $error("range");
  a_take_hold:
    assert property (take.valid && !take_ack |=> take.valid && $stable(take.chan)) else $error("hold");
  a_nest_push:
    assert property (take.valid && take_ack |=> nest_depth == $past(nest_depth) + 4'h1) else $error("nest");
  a_only_en:
    assert property (take.valid |-> chan_en[take.chan]) else $error("enable");
  a_raise_any:
    assert property (raise.valid && raise.dst < LIM && raise.src < LIM && chan_en[raise.dst]
      && !take.valid && nest_depth == 4'h0 |-> ##2 take.valid) else $error("offer");
endmodule : ics_chk
bind ics_top ics_chk #(.EXTENDED(EXTENDED)) ics_chk_inst (.clk(clk), .rstn(rstn), .raise(raise),
  .chan_en(chan_en), .take(take), .take_ack(take_ack), .nest_depth(nest_depth),
  .raise_refused(raise_refused), .cpu_chan_taken(cpu_chan_taken));

// File: test/ics_cpu_model.sv
// processor model that accepts offers, promptly or slowly
`timescale 1ns/1ns
module ics_cpu_model (
  input wire logic clk,
  input wire ics_pkg::ics_take_t take,
  input wire logic slow,
  output logic take_ack = 1'b0
);
  import ics_pkg::*;
  logic [1:0] cnt_q = '0;
  // only ring 0 deliveries are accepted; slow mode lets three falling edges pass and acks on the fourth
  always @(negedge clk) begin
    take_ack <= take.valid && !take_ack && take.ring == 2'h0 && (!slow || &cnt_q);
    cnt_q <= take.valid ? cnt_q + 2'h1 : 2'h0;
  end
endmodule : ics_cpu_model

// File: test/ics_top_test.sv
// self-checking bench for the interrupt channel system
`timescale 1ns/1ns
module ics_top_test;
  import ics_pkg::*;
  logic clk = 0, rstn = 0, slow = 0, svc_done = 0, take_ack, refd;
  logic [3:0] depth;
  logic [258:0] chan_en = '1;
  ics_raise_t raise = '0;
  ics_take_t take;
  logic cpu_f, ack_x, refd_x;
  logic [3:0] depth_x;
  ics_raise_t raise_x = '0;
  ics_take_t take_x;
  int error_cnt = 0, n_compared = 0;
  always #5 clk = ~clk;
  ics_top ics_top_inst (.clk(clk), .rstn(rstn), .raise(raise), .chan_en(chan_en), .take(take),
    .take_ack(take_ack), .svc_done(svc_done), .nest_depth(depth), .raise_refused(refd),
    .cpu_chan_taken(cpu_f));
  ics_cpu_model ics_cpu_model_inst (.clk(clk), .take(take), .slow(slow), .take_ack(take_ack));
  // second block in the extended variant, for the channels past 255
  ics_top #(.EXTENDED(1'b1)) ics_top_ext_inst (.clk(clk), .rstn(rstn), .raise(raise_x),
    .chan_en(chan_en), .take(take_x), .take_ack(ack_x), .svc_done(svc_done),
    .nest_depth(depth_x), .raise_refused(refd_x), .cpu_chan_taken());
  ics_cpu_model ics_cpu_model_ext_inst (.clk(clk), .take(take_x), .slow(1'b0),
    .take_ack(ack_x));
  task give_verdict;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %0h want %0h", $time, g, e);
    end
  endtask : chk
  // raise from channel 1 toward d; refusal shows one cycle later
  task rs(input int d, input logic r);
    @(negedge clk);
    raise = {1'b1, 9'h001, 9'(d)};
    @(negedge clk);
    raise = '0;
    chk(refd, r);
  endtask : rs
  // bounded waits: offer of c appears, then goes once accepted
  task ran_out;
    error_cnt++;
    $display("[FAIL] %0t wait ran out", $time);
    give_verdict;
  endtask : ran_out
  task offer(input int c, input int dep);
    int i;
    for (i = 0; i < 30 && take.valid !== 1'b1; i++) @(negedge clk);
    if (i == 30) ran_out;
    chk(take.chan, c);
    chk(take.ring, 0);
    chk(take.vector, 32'h0000_1000 + 32'(c) * 32'h0000_0010);
    for (i = 0; i < 30 && take.valid !== 1'b0; i++) @(negedge clk);
    if (i == 30) ran_out;
    chk(depth, dep);
  endtask : offer
  task sd;
    svc_done = 1;
    @(negedge clk);
    svc_done = 0;
    @(negedge clk);
  endtask : sd
  // cpu channel, then an i/o channel nested on top with a slow acceptor
  task t_nest;
    rs(5, 0);
    offer(5, 1);
    chk(cpu_f, 1);
    slow = 1;
    rs(20, 0);
    offer(20, 2);
    chk(cpu_f, 0);
    slow = 0;
    sd;
    sd;
    chk(depth, 0);
  endtask : t_nest
  // channels past the last are refused; the last one is delivered
  task t_range;
    rs(256, 1);
    rs(258, 1);
    rs(255, 0);
    offer(255, 1);
    sd;
  endtask : t_range
  // a disabled channel is held while an enabled one goes first
  task t_mask;
    chan_en[9] = 0;
    rs(9, 0);
    rs(30, 0);
    offer(30, 1);
    sd;
    chan_en[9] = 1;
    offer(9, 1);
    sd;
  endtask : t_mask
  // the extended variant keeps channel 258, one of the three channels past 255
  task t_ext;
    int i;
    @(negedge clk);
    raise_x = {1'b1, 9'h001, 9'h102};
    @(negedge clk);
    raise_x = '0;
    chk(refd_x, 0);
    for (i = 0; i < 30 && take_x.valid !== 1'b1; i++) @(negedge clk);
    if (i == 30) ran_out;
    chk(take_x.chan, 32'h0000_0102);
    for (i = 0; i < 30 && take_x.valid !== 1'b0; i++) @(negedge clk);
    if (i == 30) ran_out;
    chk(depth_x, 1);
    sd;
    chk(depth_x, 0);
  endtask : t_ext
  initial begin
    repeat (12) @(negedge clk);
    rstn = 1;
    t_nest;
    t_range;
    t_mask;
    t_ext;
    give_verdict;
  end
endmodule : ics_top_test
